/* ovfs_supervisor.sv */
// ovfs_supervisor: stop and overvoltage thresholds, fault response sequencer
// assumes measurements and exponent fields come from logic on clk_sys_i
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R01] reading the input stop threshold returns the sign-extended input exponent in bits 15 to 11.
// [R02] the input stop threshold keeps a writable 11-bit mantissa; value is mantissa times two to the exponent.
// [R03] conversion is stopped when the measured input voltage reaches the stop threshold.
// [R04] an output overvoltage fault is declared when the output measurement exceeds the fault threshold.
// [R05] the overvoltage threshold reads its exponent from the output format field and keeps a writable mantissa.
// [R06] a two-bit response field selects the fault action, and zero means no action.
// [R07] response 01 keeps running for delay one, then retries if the fault remains.
// [R08] response 10 shuts down at once, disables the output, then retries up to the retry count.
// [R09] response 11 disables the output until the fault is gone and then re-enables it.
// [R10] when all retries are used and the fault remains, the output stays off until cleared.
// [R11] a latched fault is cleared by reset, a power cycle, or loss of bias power.
// [R12] restart attempts are spaced by delay two chosen by the delay field.
// [R13] the retry field gives the number of restart attempts, codes 0 to 2 giving 0 to 2.
// [R14] delay one runs 10 ms doubling to 1280 ms, delay two 252 ms to 2604 ms, retry codes 3 to 6 literal, 7 unlimited.
// [R15] thresholds and measurements are expanded to a common fixed-point scale before comparing.
module ovfs_supervisor #(
	parameter int unsigned MS_CYCLES = ovfs_pkg::CLK_HZ / ovfs_pkg::MS_PER_S
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [2:0] vin_exp_i,
	input wire logic [2:0] vout_exp_i,
	input wire logic [15:0] vin_meas_i,
	input wire logic [15:0] vout_meas_i,
	input wire logic power_cycle_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_ack_o,
	output logic reg_err_o,
	output logic conv_stop_o,
	output logic ov_fault_o,
	output logic output_en_o,
	output logic fault_latched_o
);

	// ==========================================================================
	// state
	typedef struct packed {
		logic [10:0] stop_mant;
		logic [10:0] ov_mant;
		logic [7:0] resp;
		logic [15:0] rdata;
		logic ack;
		logic err;
		logic conv_stop;
		logic ov_fault;
		ovfs_pkg::ovfs_state_t st;
		logic [15:0] div;
		logic tick;
		logic [11:0] ms;
		logic [2:0] used;
	} ovfs_regs_t;

	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
	localparam ovfs_regs_t REG_RST = '{st: ovfs_pkg::ST_RUN, default: '0};

	ovfs_regs_t q;
	ovfs_regs_t next_q;

	// ==========================================================================
	// linear format helpers
	function automatic logic [4:0] sext3(input logic [2:0] e);
		sext3 = {{2{e[2]}}, e};
	endfunction : sext3

	// fixed point with EXP_BIAS fraction bits, so negative exponents lose nothing
	function automatic logic [ovfs_pkg::VAL_W-1:0] expand(input logic [15:0] lin);
		logic [5:0] amt;
		// 5-bit wrap maps exponent -16..15 onto shifts 0..31
		amt = {1'b0, lin[ovfs_pkg::EXP_MSB:ovfs_pkg::EXP_LSB] + 5'(ovfs_pkg::EXP_BIAS)};
		expand = ovfs_pkg::VAL_W'(lin[ovfs_pkg::MANT_MSB:0]) << amt;
	endfunction : expand

	logic [15:0] stop_word;
	logic [15:0] ovlim_word;
	logic [1:0] resp_code;
	logic [2:0] retry_code;
	logic [2:0] dly_code;
	logic [11:0] dly1;
	logic can_retry;

	assign stop_word = {sext3(vin_exp_i), q.stop_mant}; // R01 R02
	assign ovlim_word = {sext3(vout_exp_i), q.ov_mant}; // R05
	assign resp_code = q.resp[ovfs_pkg::RESP_MSB:ovfs_pkg::RESP_LSB];
	assign retry_code = q.resp[ovfs_pkg::RETRY_MSB:ovfs_pkg::RETRY_LSB];
	assign dly_code = q.resp[ovfs_pkg::DLY_MSB:ovfs_pkg::DLY_LSB];
	assign dly1 = ovfs_pkg::DLY1_BASE_MS << dly_code; // R14
	assign can_retry = (retry_code == ovfs_pkg::RETRY_INF) || (q.used < retry_code); // R13 R14

	// ==========================================================================
	// next state
	always_comb
	begin
		next_q = q;
		next_q.ack = reg_wr_i | reg_rd_i;
		next_q.err = 1'b0;
		// millisecond enable pulse keeps the delay counters at 12 bits
		if (q.div == MS_LAST)
		begin
			next_q.div = '0;
			next_q.tick = 1'b1;
		end
		else
		begin
			next_q.div = q.div + 16'h0001;
			next_q.tick = 1'b0;
		end

		// register access; exponent bits are read-only and ignored on write
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				ovfs_pkg::ADDR_STOP: next_q.stop_mant = reg_wdata_i[ovfs_pkg::MANT_MSB:0]; // R02
				ovfs_pkg::ADDR_OVLIM: next_q.ov_mant = reg_wdata_i[ovfs_pkg::MANT_MSB:0]; // R05
				ovfs_pkg::ADDR_RESP: next_q.resp = reg_wdata_i[ovfs_pkg::RESP_MSB:ovfs_pkg::DLY_LSB]; // R06
				default: next_q.err = 1'b1;
			endcase
		end
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				ovfs_pkg::ADDR_STOP: next_q.rdata = stop_word; // R01
				ovfs_pkg::ADDR_OVLIM: next_q.rdata = ovlim_word; // R05
				ovfs_pkg::ADDR_RESP: next_q.rdata = {8'h00, q.resp};
				default:
				begin
					next_q.rdata = '0;
					next_q.err = 1'b1;
				end
			endcase
		end

		next_q.conv_stop = expand(vin_meas_i) >= expand(stop_word); // R03 R15
		next_q.ov_fault = expand(vout_meas_i) > expand(ovlim_word); // R04 R15

		// fault response sequencer
		case (q.st)
			ovfs_pkg::ST_RUN:
			begin
				if (q.tick && !q.ov_fault)
					next_q.used = '0;
				if (q.ov_fault)
				begin
					case (resp_code)
						ovfs_pkg::RESP_RIDE:
						begin
							next_q.st = ovfs_pkg::ST_RIDE; // R07
							next_q.ms = dly1; // R14
						end
						ovfs_pkg::RESP_RETRY:
						begin
							next_q.st = can_retry ? ovfs_pkg::ST_WAIT : ovfs_pkg::ST_LATCH; // R08 R10
							next_q.ms = ovfs_pkg::dly2_ms(dly_code); // R12
						end
						ovfs_pkg::RESP_HOLD: next_q.st = ovfs_pkg::ST_HOLD; // R09
						default: next_q.st = ovfs_pkg::ST_RUN; // R06
					endcase
				end
			end
			ovfs_pkg::ST_RIDE:
			begin
				if (!q.ov_fault)
					next_q.st = ovfs_pkg::ST_RUN;
				else if (q.ms == '0)
				begin
					next_q.st = can_retry ? ovfs_pkg::ST_WAIT : ovfs_pkg::ST_LATCH; // R07 R10
					next_q.ms = ovfs_pkg::dly2_ms(dly_code); // R12
				end
				else if (q.tick)
					next_q.ms = q.ms - 12'h001;
			end
			ovfs_pkg::ST_WAIT:
			begin
				if (q.ms == '0)
				begin
					next_q.st = ovfs_pkg::ST_RUN; // R12
					if (q.used != ovfs_pkg::RETRY_INF)
						next_q.used = q.used + 3'h1; // R13
				end
				else if (q.tick)
					next_q.ms = q.ms - 12'h001;
			end
			ovfs_pkg::ST_HOLD:
			begin
				if (!q.ov_fault)
					next_q.st = ovfs_pkg::ST_RUN; // R09
			end
			ovfs_pkg::ST_LATCH: next_q.st = ovfs_pkg::ST_LATCH; // R10
			default: next_q.st = ovfs_pkg::ST_RUN;
		endcase

		// power cycle takes precedence over any sequencer step
		if (power_cycle_i)
		begin
			next_q.st = ovfs_pkg::ST_RUN; // R11
			next_q.used = '0;
		end
	end

	// ==========================================================================
	// registers; reset also models loss of bias
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			q <= REG_RST; // R11
		else
			q <= next_q;
	end

	assign reg_rdata_o = q.rdata;
	assign reg_ack_o = q.ack;
	assign reg_err_o = q.err;
	assign conv_stop_o = q.conv_stop;
	assign ov_fault_o = q.ov_fault;
	assign output_en_o = (q.st == ovfs_pkg::ST_RUN) || (q.st == ovfs_pkg::ST_RIDE);
	assign fault_latched_o = (q.st == ovfs_pkg::ST_LATCH);

	// ==========================================================================
	// assertions
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	sequence s_fault_in_run(logic [1:0] code);
		q.st == ovfs_pkg::ST_RUN && q.ov_fault && resp_code == code && !power_cycle_i;
	endsequence

	sequence s_off_hold;
		!output_en_o [*8];
	endsequence

	property p_stop_exp;
		reg_rd_i && reg_addr_i == ovfs_pkg::ADDR_STOP |=> reg_rdata_o[15:11] == sext3($past(vin_exp_i));
	endproperty
	a_stop_exp: assert property (p_stop_exp) else $error("stop exponent wrong"); // R01

	property p_stop_mant;
		reg_wr_i && reg_addr_i == ovfs_pkg::ADDR_STOP ##1 reg_rd_i && reg_addr_i == ovfs_pkg::ADDR_STOP
			|=> reg_rdata_o[10:0] == $past(reg_wdata_i[10:0], 2);
	endproperty
	a_stop_mant: assert property (p_stop_mant) else $error("stop mantissa not kept"); // R02

	property p_conv_stop;
		arst_n_i ##1 1'b1 |-> conv_stop_o == (expand($past(vin_meas_i)) >= expand($past(stop_word)));
	endproperty
	a_conv_stop: assert property (p_conv_stop) else $error("stop compare wrong"); // R03

	property p_ov_flag;
		arst_n_i ##1 1'b1 |-> ov_fault_o == (expand($past(vout_meas_i)) > expand($past(ovlim_word)));
	endproperty
	a_ov_flag: assert property (p_ov_flag) else $error("overvoltage compare wrong"); // R04

	property p_ov_exp;
		reg_rd_i && reg_addr_i == ovfs_pkg::ADDR_OVLIM |=> reg_rdata_o[15:11] == sext3($past(vout_exp_i));
	endproperty
	a_ov_exp: assert property (p_ov_exp) else $error("limit exponent wrong"); // R05

	property p_none;
		s_fault_in_run(ovfs_pkg::RESP_NONE) |=> output_en_o;
	endproperty
	a_none: assert property (p_none) else $error("code zero acted"); // R06

	property p_ride;
		s_fault_in_run(ovfs_pkg::RESP_RIDE) |=> q.st == ovfs_pkg::ST_RIDE && output_en_o ##1 output_en_o;
	endproperty
	a_ride: assert property (p_ride) else $error("ride through dropped output"); // R07

	property p_shut;
		s_fault_in_run(ovfs_pkg::RESP_RETRY) |=> !output_en_o;
	endproperty
	a_shut: assert property (p_shut) else $error("no immediate shutdown"); // R08

	property p_hold;
		q.st == ovfs_pkg::ST_HOLD && !q.ov_fault && !power_cycle_i |=> output_en_o;
	endproperty
	a_hold: assert property (p_hold) else $error("hold did not release"); // R09

	property p_latch;
		fault_latched_o && !power_cycle_i |=> fault_latched_o && !output_en_o;
	endproperty
	a_latch: assert property (p_latch) else $error("latched fault left"); // R10

	property p_clear;
		power_cycle_i |=> output_en_o && !fault_latched_o;
	endproperty
	a_clear: assert property (p_clear) else $error("power cycle not cleared"); // R11

	// a power cycle may restart the output inside the wait
	property p_spacing;
		disable iff (!arst_n_i || power_cycle_i)
		q.st != ovfs_pkg::ST_WAIT ##1 q.st == ovfs_pkg::ST_WAIT && !power_cycle_i |-> s_off_hold;
	endproperty
	a_spacing: assert property (p_spacing) else $error("restart too early"); // R12

	property p_zero_retry;
		s_fault_in_run(ovfs_pkg::RESP_RETRY) and retry_code == 3'h0 |=> fault_latched_o;
	endproperty
	a_zero_retry: assert property (p_zero_retry) else $error("retry code zero retried"); // R13

endmodule : ovfs_supervisor

`default_nettype wire

/* ovfs_pkg.sv */
// ovfs_pkg: constants, codes and state encoding for the output overvoltage supervisor
// assumes a single 40 MHz system clock; register access by command code on the management bus
`default_nettype none
package ovfs_pkg;

	// ==========================================================================
	// command codes
	localparam logic [7:0] ADDR_STOP = 8'h36;
	localparam logic [7:0] ADDR_OVLIM = 8'h40;
	localparam logic [7:0] ADDR_RESP = 8'h41;

	// ==========================================================================
	// field layout
	localparam int EXP_MSB = 15;
	localparam int EXP_LSB = 11;
	localparam int MANT_MSB = 10;
	localparam int RESP_MSB = 7;
	localparam int RESP_LSB = 6;
	localparam int RETRY_MSB = 5;
	localparam int RETRY_LSB = 3;
	localparam int DLY_MSB = 2;
	localparam int DLY_LSB = 0;
	localparam int EXP_BIAS = 16;
	localparam int VAL_W = 43;

	// ==========================================================================
	// response and retry codes
	localparam logic [1:0] RESP_NONE = 2'h0;
	localparam logic [1:0] RESP_RIDE = 2'h1;
	localparam logic [1:0] RESP_RETRY = 2'h2;
	localparam logic [1:0] RESP_HOLD = 2'h3;
	localparam logic [2:0] RETRY_INF = 3'h7;

	// ==========================================================================
	// timing
	localparam int CLK_HZ = 40000000;
	localparam int MS_PER_S = 1000;
	localparam logic [11:0] DLY1_BASE_MS = 12'h00a;
	localparam logic [11:0] DLY2_0_MS = 12'h0fc;
	localparam logic [11:0] DLY2_1_MS = 12'h22e;
	localparam logic [11:0] DLY2_2_MS = 12'h39c;
	localparam logic [11:0] DLY2_3_MS = 12'h4ec;
	localparam logic [11:0] DLY2_4_MS = 12'h63c;
	localparam logic [11:0] DLY2_5_MS = 12'h78c;
	localparam logic [11:0] DLY2_6_MS = 12'h8dc;
	localparam logic [11:0] DLY2_7_MS = 12'ha2c;

	function automatic logic [11:0] dly2_ms(input logic [2:0] code);
		case (code)
			3'h0: dly2_ms = DLY2_0_MS;
			3'h1: dly2_ms = DLY2_1_MS;
			3'h2: dly2_ms = DLY2_2_MS;
			3'h3: dly2_ms = DLY2_3_MS;
			3'h4: dly2_ms = DLY2_4_MS;
			3'h5: dly2_ms = DLY2_5_MS;
			3'h6: dly2_ms = DLY2_6_MS;
			default: dly2_ms = DLY2_7_MS;
		endcase
	endfunction : dly2_ms

	// ==========================================================================
	// supervisor states
	typedef enum logic [4:0] {
		ST_RUN = 5'b00001,
		ST_RIDE = 5'b00010,
		ST_WAIT = 5'b00100,
		ST_HOLD = 5'b01000,
		ST_LATCH = 5'b10000
	} ovfs_state_t;

endpackage : ovfs_pkg

`default_nettype wire

/* ovfs_host.sv */
// ovfs_host: management bus host model issuing single register accesses
// assumes the register port answers with ack one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module ovfs_host (
	input wire logic clk_sys_i,
	input wire logic [15:0] reg_rdata_i,
	input wire logic reg_ack_i,
	input wire logic reg_err_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [15:0] reg_wdata_o
);
	// ==========
	// access task
	initial
	begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 16'h0000;
	end
	// strobe is a single-cycle pulse, address and data held until the ack edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q,
		output logic k, output logic e);
		@(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_wr_o <= wr;
		reg_rd_o <= ~wr;
		reg_wdata_o <= d;
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		@(posedge clk_sys_i);
		q = reg_rdata_i;
		k = reg_ack_i;
		e = reg_err_i;
		// stale data would hide a late sample
		reg_wdata_o <= ~d;
	endtask : xfer
endmodule : ovfs_host
`default_nettype wire

/* tb_output_ov_fault_supervisor.sv */
// tb_output_ov_fault_supervisor: self-checking bench for the overvoltage supervisor
// assumes ovfs_host on the register port; ms tick shortened through MS_CYCLES
`timescale 1ns/1ps
`default_nettype none
module tb_output_ov_fault_supervisor;
	localparam int MS = 4;
	int d2[8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [7:0] reg_addr_i;
	logic reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, conv_stop_o, ov_fault_o;
	logic output_en_o, fault_latched_o, power_cycle_i;
	logic [15:0] reg_wdata_i, reg_rdata_o, vin_meas_i, vout_meas_i;
	logic [2:0] vin_exp_i, vout_exp_i;
	logic [31:0] rng = 32'h46929f09;
	int n_errors = 0;
	int total_checks = 0;
	int shadow[int];
	always #12.5 clk_sys_i = ~clk_sys_i;
	ovfs_supervisor #(.MS_CYCLES(MS)) dut_u (.clk_sys_i, .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
		.reg_wdata_i, .vin_exp_i, .vout_exp_i, .vin_meas_i, .vout_meas_i, .power_cycle_i, .reg_rdata_o,
		.reg_ack_o, .reg_err_o, .conv_stop_o, .ov_fault_o, .output_en_o, .fault_latched_o);
	ovfs_host host_u (.clk_sys_i, .reg_rdata_i(reg_rdata_o), .reg_ack_i(reg_ack_o), .reg_err_i(reg_err_o),
		.reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
	// ==========
	// model helpers
	function logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : rnd
	function automatic longint xp(input logic [15:0] w);
		return longint'(w[10:0]) << (int'($signed(w[15:11])) + 16);
	endfunction : xp
	function automatic logic [15:0] lin(input logic [2:0] e, input logic [10:0] m);
		return {{2{e[2]}}, e, m};
	endfunction : lin
	// register model: writable mantissa or response byte, exponent mirrored from its field
	function automatic logic [15:0] mdl_rd(input logic [7:0] a);
		int m;
		m = shadow.exists(a) ? shadow[a] : 0;
		case (a)
			ovfs_pkg::ADDR_STOP: return lin(vin_exp_i, 11'(m));
			ovfs_pkg::ADDR_OVLIM: return lin(vout_exp_i, 11'(m));
			ovfs_pkg::ADDR_RESP: return 16'(m);
			default: return 16'h0000;
		endcase
	endfunction : mdl_rd
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		logic k, e;
		host_u.xfer(wr, a, d, q, k, e);
		chk({k, e}, {1'b1, !(a inside {ovfs_pkg::ADDR_STOP, ovfs_pkg::ADDR_OVLIM, ovfs_pkg::ADDR_RESP})});
		if (wr)
			shadow[a] = (a == ovfs_pkg::ADDR_RESP) ? int'(d[7:0]) : int'(d[10:0]);
		else
			chk(q, mdl_rd(a));
	endtask : acc
	// bounded wait for output enable level, span checked against lo..hi edges
	task automatic wen(input logic lvl, input int lo, input int hi);
		int n;
		n = 0;
		while (output_en_o !== lvl && n <= hi)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		chk(n >= lo && n <= hi, 1'b1);
	endtask : wen
	task automatic pcyc();
		power_cycle_i <= 1'b1;
		@(posedge clk_sys_i);
		power_cycle_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask : pcyc
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	// ==========
	// scenarios
	initial
	begin
		logic [31:0] x;
		logic [15:0] q;
		logic [10:0] d;
		logic [2:0] r;
		vin_exp_i = 3'h5;
		vout_exp_i = 3'h3;
		vin_meas_i = 16'h0000;
		vout_meas_i = 16'h0000;
		power_cycle_i = 1'b0;
		repeat (10) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		chk(output_en_o, 1'b1);
		acc(0, ovfs_pkg::ADDR_STOP, 16'h0000, q);
		chk(q, lin(3'h5, 11'h000));
		acc(0, ovfs_pkg::ADDR_OVLIM, 16'h0000, q);
		chk(q, lin(3'h3, 11'h000));
		acc(1, 8'h37, 16'hffff, q);
		acc(0, 8'h37, 16'h0000, q);
		chk(q, 16'h0000);
		// near-equal and shifted-exponent measurements hit the compare boundary
		for (int i = 0; i < 12; i++)
		begin
			x = rnd();
			d = 11'(i % 3) - 11'h001;
			vin_exp_i <= x[2:0];
			vout_exp_i <= x[5:3];
			acc(1, ovfs_pkg::ADDR_STOP, {x[31:27], x[16:6]}, q);
			acc(1, ovfs_pkg::ADDR_OVLIM, {x[27:23], ~x[16:6]}, q);
			acc(0, ovfs_pkg::ADDR_STOP, 16'h0000, q);
			chk(q, lin(x[2:0], x[16:6]));
			acc(0, ovfs_pkg::ADDR_OVLIM, 16'h0000, q);
			chk(q, lin(x[5:3], ~x[16:6]));
			vin_meas_i <= {{{2{x[2]}}, x[2:0]} - 5'(i / 6), (i < 6) ? x[16:6] + d : {x[15:6], 1'b0} + d};
			vout_meas_i <= i[0] ? 16'(rnd()) : lin(x[5:3], ~x[16:6] + d);
			repeat (3) @(posedge clk_sys_i);
			chk(conv_stop_o, xp(vin_meas_i) >= xp(lin(x[2:0], x[16:6])));
			chk(ov_fault_o, xp(vout_meas_i) > xp(lin(x[5:3], ~x[16:6])));
		end
		vout_exp_i <= 3'h0;
		vout_meas_i <= 16'h0100;
		acc(1, ovfs_pkg::ADDR_OVLIM, 16'h0100, q);
		acc(1, ovfs_pkg::ADDR_RESP, 16'h0000, q);
		vout_meas_i <= 16'h0101;
		repeat (60) @(posedge clk_sys_i);
		chk({ov_fault_o, output_en_o, fault_latched_o}, 3'b110);
		vout_meas_i <= 16'h0100;
		acc(1, ovfs_pkg::ADDR_RESP, 16'h00c0, q);
		vout_meas_i <= 16'h0101;
		wen(1'b0, 1, 4);
		repeat (20) @(posedge clk_sys_i);
		vout_meas_i <= 16'h0100;
		wen(1'b1, 1, 4);
		acc(1, ovfs_pkg::ADDR_RESP, 16'hff42, q);
		acc(0, ovfs_pkg::ADDR_RESP, 16'h0000, q);
		chk(q, 16'h0042);
		vout_meas_i <= 16'h0101;
		wen(1'b0, 39 * MS, 41 * MS + 4);
		chk(fault_latched_o, 1'b1);
		vout_meas_i <= 16'h0100;
		pcyc();
		chk({output_en_o, fault_latched_o}, 2'b10);
		for (int i = 0; i < 4; i++)
		begin
			r = (i == 3) ? 3'h7 : 3'(i);
			acc(1, ovfs_pkg::ADDR_RESP, {8'h00, 2'b10, r, 3'(i)}, q);
			vout_meas_i <= 16'h0101;
			for (int j = 0; j < ((i == 3) ? 3 : i); j++)
			begin
				wen(1'b0, 1, 4);
				wen(1'b1, (d2[i] - 1) * MS, (d2[i] + 1) * MS + 4);
			end
			wen(1'b0, 1, 4);
			chk(fault_latched_o, i != 3);
			vout_meas_i <= 16'h0100;
			repeat ((d2[i] + 2) * MS + 8) @(posedge clk_sys_i);
			chk(output_en_o, i == 3);
			pcyc();
		end
		acc(1, ovfs_pkg::ADDR_RESP, 16'h0080, q);
		vout_meas_i <= 16'h0101;
		wen(1'b0, 1, 4);
		arst_n_i <= 1'b0;
		shadow.delete();
		@(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		chk({output_en_o, fault_latched_o}, 2'b10);
		end_of_test();
	end
	// run needs about 37000 cycles; limit leaves more than twice that
	initial
	begin
		repeat (100000) @(posedge clk_sys_i);
		n_errors++;
		end_of_test();
	end
endmodule : tb_output_ov_fault_supervisor
`default_nettype wire
